// ### rtl/wiper_ctl_pkg.sv
// constants and types shared by the up/down wiper controller
package wiper_ctl_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses, one aligned word each)
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W      = 12;
   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_DIV    = 12'h008;
   localparam logic [11:0] ADDR_SHADOW = 12'h00C;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_GO_BIT    = 0;
   localparam int unsigned CTRL_ELEV_BIT  = 1;
   localparam int unsigned CTRL_UP_BIT    = 2;
   localparam int unsigned CTRL_KEEP_BIT  = 3;
   localparam int unsigned CTRL_STEPS_LSB = 8;
   localparam int unsigned CTRL_STEPS_MSB = 14;
   localparam int unsigned STAT_BUSY_BIT  = 0;
   localparam int unsigned STAT_DONE_BIT  = 1;
   localparam int unsigned STAT_FRZ_BIT   = 2;
   localparam int unsigned STAT_POS_LSB   = 8;
   localparam int unsigned STAT_POS_MSB   = 13;
   localparam int unsigned STAT_NV_LSB    = 16;
   localparam int unsigned STAT_NV_MSB    = 21;
   localparam int unsigned SHD_FRZ_BIT    = 8;

   // ----------------------------------------------------------------
   // wiper codes and reset values
   // ----------------------------------------------------------------
   localparam int unsigned POS_W       = 6;
   localparam int unsigned STEPS_W     = 7;
   localparam int unsigned DIV_W       = 16;
   localparam logic [5:0]  POS_TOP     = 6'h3F;
   localparam logic [5:0]  POS_BOTTOM  = 6'h00;
   localparam logic [5:0]  POS_DEFAULT = 6'h1F;
   localparam logic [6:0]  STEPS_MAX   = 7'h40;
   localparam logic [15:0] DIV_RESET   = 16'h0031;

   // ----------------------------------------------------------------
   // pin levels and sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CS_IDLE_HIGH,
      CS_LOW_SELECT,
      CS_ELEVATED
   } cs_level_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_SELECT,
      ST_LOW,
      ST_HIGH,
      ST_FINAL,
      ST_RELEASE
   } seq_state_t;

endpackage : wiper_ctl_pkg

// ### rtl/phase_tick.sv
// divider giving a one-cycle enable every div+1 clocks while running
`timescale 1ns/1ns
module phase_tick (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        run,
   input  wire logic [15:0] div,
   output logic             tick
);
   import wiper_ctl_pkg::*;

   logic [DIV_W-1:0] cnt_r;
   logic [DIV_W-1:0] cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (!run || cnt_r >= div) begin
         cnt_nxt = '0;
      end else begin
         cnt_nxt = cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign tick = run && (cnt_r >= div);

endmodule : phase_tick

// ### rtl/sat_step.sv
// one saturating step of the 6-bit wiper code
`timescale 1ns/1ns
module sat_step (
   input  wire logic [5:0] pos,
   input  wire logic       up,
   output logic [5:0]      pos_stepped
);
   import wiper_ctl_pkg::*;

   always_comb begin
      pos_stepped = pos;
      if (up && pos != POS_TOP) begin
         pos_stepped = pos + 6'h01;
      end else if (!up && pos != POS_BOTTOM) begin
         pos_stepped = pos - 6'h01;
      end
   end

endmodule : sat_step

// ### rtl/wiper_ctl.sv
// apb-programmed controller driving the chip-select and step/direction pins
// ----------------------------------------------------------------
// Functional notes
// - low select from idle starts a normal step command, store optional.
// - elevated select from idle starts a command that steps, always stores and sets or clears freeze.
// - step input level at select entry picks up or down; set beforehand.
// - step input level at chip-select release decides storing, or freeze when elevated.
// ----------------------------------------------------------------
`timescale 1ns/1ns
module wiper_ctl (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [wiper_ctl_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                 pwdata,
   output logic [31:0]                      prdata,
   output logic                             pready,
   output logic                             pslverr,
   output logic                             cs_oe,
   output wiper_ctl_pkg::cs_level_t         cs_level,
   output logic                             ud_out
);
   import wiper_ctl_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   seq_state_t             st_r, st_nxt;
   logic                   elev_r, elev_nxt;
   logic                   up_r, up_nxt;
   logic                   keep_r, keep_nxt;
   logic [STEPS_W-1:0]     steps_r, steps_nxt;
   logic [DIV_W-1:0]       div_r, div_nxt;
   logic [POS_W-1:0]       pos_r, pos_nxt;
   logic [POS_W-1:0]       nv_pos_r, nv_pos_nxt;
   logic                   freeze_r, freeze_nxt;
   logic                   done_r, done_nxt;
   logic                   ud_r, ud_nxt;
   logic [31:0]            prdata_r, prdata_nxt;
   logic                   tick;
   logic [POS_W-1:0]       pos_stepped;
   logic                   wr_acc, rd_setup, mapped;

   assign wr_acc   = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign mapped   = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                     (paddr == ADDR_DIV) || (paddr == ADDR_SHADOW);

   phase_tick u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (st_r != ST_IDLE),
      .div     (div_r),
      .tick    (tick)
   );

   sat_step u_step (
      .pos         (pos_r),
      .up          (up_r),
      .pos_stepped (pos_stepped)
   );

   // ----------------------------------------------------------------
   // apb slave: zero wait states, error on unmapped
   // ----------------------------------------------------------------
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata  = prdata_r;

   always_comb begin
      prdata_nxt = prdata_r;
      if (rd_setup) begin
         prdata_nxt = '0;
         case (paddr)
            ADDR_CTRL: begin
               prdata_nxt[CTRL_ELEV_BIT] = elev_r;
               prdata_nxt[CTRL_UP_BIT]   = up_r;
               prdata_nxt[CTRL_KEEP_BIT] = keep_r;
               prdata_nxt[CTRL_STEPS_MSB:CTRL_STEPS_LSB] = steps_r;
            end
            ADDR_STATUS: begin
               prdata_nxt[STAT_BUSY_BIT] = (st_r != ST_IDLE);
               prdata_nxt[STAT_DONE_BIT] = done_r;
               prdata_nxt[STAT_FRZ_BIT]  = freeze_r;
               prdata_nxt[STAT_POS_MSB:STAT_POS_LSB] = pos_r;      // host-side model, device is write-only
               prdata_nxt[STAT_NV_MSB:STAT_NV_LSB]   = nv_pos_r;
            end
            ADDR_DIV:    prdata_nxt[DIV_W-1:0] = div_r;
            ADDR_SHADOW: begin
               prdata_nxt[POS_W-1:0]   = pos_r;
               prdata_nxt[SHD_FRZ_BIT] = freeze_r;
            end
            default: prdata_nxt = '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // command sequencer
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt     = st_r;
      elev_nxt   = elev_r;
      up_nxt     = up_r;
      keep_nxt   = keep_r;
      steps_nxt  = steps_r;
      div_nxt    = div_r;
      pos_nxt    = pos_r;
      nv_pos_nxt = nv_pos_r;
      freeze_nxt = freeze_r;
      done_nxt   = done_r;
      ud_nxt     = ud_r;
      if (wr_acc && paddr == ADDR_DIV) begin
         div_nxt = pwdata[DIV_W-1:0];
      end
      if (st_r == ST_IDLE && wr_acc && paddr == ADDR_SHADOW) begin
         pos_nxt    = pwdata[POS_W-1:0];
         nv_pos_nxt = pwdata[POS_W-1:0];
         freeze_nxt = pwdata[SHD_FRZ_BIT];
      end
      case (st_r)
         ST_IDLE: begin
            if (wr_acc && paddr == ADDR_CTRL && pwdata[CTRL_GO_BIT]) begin
               elev_nxt  = pwdata[CTRL_ELEV_BIT];
               up_nxt    = pwdata[CTRL_UP_BIT];
               keep_nxt  = pwdata[CTRL_KEEP_BIT];
               steps_nxt = (pwdata[CTRL_STEPS_MSB:CTRL_STEPS_LSB] > STEPS_MAX) ?
                           STEPS_MAX : pwdata[CTRL_STEPS_MSB:CTRL_STEPS_LSB];   // 64 codes at most
               ud_nxt    = pwdata[CTRL_UP_BIT];                                // direction set before select
               done_nxt  = 1'b0;
               st_nxt    = ST_SETUP;
            end
         end
         ST_SETUP: begin
            if (tick) begin
               st_nxt = ST_SELECT;                                            // select edge with ud stable
            end
         end
         ST_SELECT: begin
            if (tick) begin
               st_nxt = (steps_r == '0) ? ST_FINAL : ST_LOW;
               if (steps_r == '0) begin
                  ud_nxt = keep_r & ud_r;                                     // never a rising edge here
               end else begin
                  ud_nxt = 1'b0;
               end
            end
         end
         ST_LOW: begin
            if (tick) begin
               ud_nxt    = 1'b1;                                              // rise steps the device
               steps_nxt = steps_r - 7'h01;
               st_nxt    = ST_HIGH;
               if (elev_r || !freeze_r) begin
                  pos_nxt = pos_stepped;                                      // saturating one-code move
               end
            end
         end
         ST_HIGH: begin
            if (tick) begin
               if (steps_r != '0) begin
                  ud_nxt = 1'b0;
                  st_nxt = ST_LOW;
               end else begin
                  ud_nxt = keep_r;                                            // store/freeze choice
                  st_nxt = ST_FINAL;
               end
            end
         end
         ST_FINAL: begin
            if (tick) begin
               st_nxt = ST_RELEASE;
               if (elev_r) begin
                  nv_pos_nxt = pos_r;                                         // elevated always stores
                  freeze_nxt = ud_r;
               end else if (ud_r && !freeze_r) begin
                  nv_pos_nxt = pos_r;
               end
            end
         end
         ST_RELEASE: begin
            if (tick) begin
               st_nxt   = ST_IDLE;                                            // chip select left undriven
               done_nxt = 1'b1;
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r     <= ST_IDLE;
         elev_r   <= 1'b0;
         up_r     <= 1'b0;
         keep_r   <= 1'b0;
         steps_r  <= '0;
         div_r    <= DIV_RESET;
         pos_r    <= POS_DEFAULT;                                             // factory mid-scale
         nv_pos_r <= POS_DEFAULT;
         freeze_r <= 1'b0;
         done_r   <= 1'b0;
         ud_r     <= 1'b0;
         prdata_r <= '0;
      end else begin
         st_r     <= st_nxt;
         elev_r   <= elev_nxt;
         up_r     <= up_nxt;
         keep_r   <= keep_nxt;
         steps_r  <= steps_nxt;
         div_r    <= div_nxt;
         pos_r    <= pos_nxt;
         nv_pos_r <= nv_pos_nxt;
         freeze_r <= freeze_nxt;
         done_r   <= done_nxt;
         ud_r     <= ud_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------
   logic cs_active;
   assign cs_active = (st_r == ST_SELECT) || (st_r == ST_LOW) ||
                      (st_r == ST_HIGH) || (st_r == ST_FINAL);
   assign cs_oe    = (st_r != ST_IDLE);
   assign cs_level = !cs_active ? CS_IDLE_HIGH :
                     (elev_r ? CS_ELEVATED : CS_LOW_SELECT);                  // two high levels kept apart
   assign ud_out   = ud_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_step_top;
      st_r == ST_LOW && tick && up_r && pos_r == POS_TOP;
   endsequence

   property p_sat_top;
      @(posedge pclk) disable iff (!presetn) s_step_top |=> pos_r == POS_TOP;
   endproperty
   a_sat_top: assert property (p_sat_top) else $error("wiper code wrapped above top");

   property p_sat_bottom;
      @(posedge pclk) disable iff (!presetn)
         (st_r == ST_LOW && tick && !up_r && pos_r == POS_BOTTOM) |=> pos_r == POS_BOTTOM;
   endproperty
   a_sat_bottom: assert property (p_sat_bottom) else $error("wiper code wrapped below bottom");

   property p_one_step_up;
      @(posedge pclk) disable iff (!presetn)
         (st_r == ST_LOW && tick && up_r && !freeze_r && pos_r != POS_TOP) |=> pos_r == $past(pos_r) + 6'h01;
   endproperty
   a_one_step_up: assert property (p_one_step_up) else $error("increment not exactly one code");

   property p_select_dir;
      @(posedge pclk) disable iff (!presetn)
         (st_r == ST_SETUP && tick) |=> cs_level != CS_IDLE_HIGH && ud_out == up_r && $stable(ud_out);
   endproperty
   a_select_dir: assert property (p_select_dir) else $error("direction not set at select edge");

   property p_frozen_normal;
      @(posedge pclk) disable iff (!presetn)
         (cs_level == CS_LOW_SELECT && freeze_r) |=> $stable(pos_r) && $stable(nv_pos_r);
   endproperty
   a_frozen_normal: assert property (p_frozen_normal) else $error("frozen normal command changed code");

   property p_elev_steps;
      @(posedge pclk) disable iff (!presetn)
         (st_r == ST_LOW && tick && elev_r && pos_r != pos_stepped) |=> pos_r != $past(pos_r);
   endproperty
   a_elev_steps: assert property (p_elev_steps) else $error("elevated command failed to step");

   sequence s_elev_end;
      st_r == ST_FINAL && tick && elev_r;
   endsequence

   property p_elev_store;
      @(posedge pclk) disable iff (!presetn)
         s_elev_end |=> nv_pos_r == pos_r && cs_oe && freeze_r == $past(ud_out);
   endproperty
   a_elev_store: assert property (p_elev_store) else $error("elevated command did not store");

   property p_undriven_idle;
      @(posedge pclk) disable iff (!presetn) !cs_oe |-> cs_level == CS_IDLE_HIGH && st_r == ST_IDLE;
   endproperty
   a_undriven_idle: assert property (p_undriven_idle) else $error("chip select level while undriven");

   property p_hold_type;
      @(posedge pclk) disable iff (!presetn)
         (cs_level != CS_IDLE_HIGH) |=> (cs_level == CS_IDLE_HIGH) || ($stable(elev_r) && $stable(up_r));
   endproperty
   a_hold_type: assert property (p_hold_type) else $error("command type changed mid-command");

   property p_release_ud;
      @(posedge pclk) disable iff (!presetn)
         (st_r == ST_FINAL && tick) |=> cs_level == CS_IDLE_HIGH && $stable(ud_out);
   endproperty
   a_release_ud: assert property (p_release_ud) else $error("step input moved at release");

endmodule : wiper_ctl

// ### bench/wiper_dev_model.sv
// behavioural model of the up/down wiper device on the far side of the pins
`timescale 1ns/1ns
module wiper_dev_model
   import wiper_ctl_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       cs_oe,
   input  wire cs_level_t  cs_level,
   input  wire logic       ud_out,
   output logic [5:0]      dev_pos,
   output logic [5:0]      dev_nv,
   output logic            dev_frz,
   output int              dev_faults
);
   // ----------------------------------------------------------------
   // pin sampling and command decode
   // ----------------------------------------------------------------
   cs_level_t line_now;
   cs_level_t line_was = CS_IDLE_HIGH;
   logic      ud_was   = 1'b0;
   logic      up_lat   = 1'b0;
   logic      elev_lat = 1'b0;
   logic      active   = 1'b0;

   // power-up recall of factory setting
   initial begin
      dev_pos    = 6'h1F;
      dev_nv     = 6'h1F;
      dev_frz    = 1'b0;
      dev_faults = 0;
   end

   // floating select reads as idle high
   assign line_now = cs_oe ? cs_level : CS_IDLE_HIGH;

   always @(posedge pclk) begin
      // direction pin must be steady across every select edge
      if (line_now != line_was && ud_out !== ud_was) dev_faults++;
      if (line_was == CS_IDLE_HIGH && line_now != CS_IDLE_HIGH) begin
         up_lat   = ud_out;
         elev_lat = (line_now == CS_ELEVATED);
         active   = 1'b1;
      end else if (active && line_now == CS_IDLE_HIGH) begin
         if (elev_lat) begin
            dev_frz = ud_out;
            dev_nv  = dev_pos;
         end else if (ud_out && !dev_frz) begin
            dev_nv = dev_pos;
         end
         active = 1'b0;
      end else if (active && line_now != line_was) begin
         dev_faults++;
      end else if (active && ud_out && !ud_was && (elev_lat || !dev_frz)) begin
         if (up_lat) dev_pos = (dev_pos == 6'h3F) ? dev_pos : dev_pos + 6'h01;
         else dev_pos = (dev_pos == 6'h00) ? dev_pos : dev_pos - 6'h01;
      end
      line_was = line_now;
      ud_was   = ud_out;
   end
endmodule : wiper_dev_model

// ### bench/wiper_ctl_tb.sv
// self-checking bench for the apb wiper step controller
`timescale 1ns/1ns
module wiper_ctl_tb;
   import wiper_ctl_pkg::*;
   // ----------------------------------------------------------------
   // signals and instances
   // ----------------------------------------------------------------
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        cs_oe, ud_out, dev_frz, efrz, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0]  dev_pos, dev_nv, epos, env;
   cs_level_t   cs_level;
   int          dev_faults, bad_count, n_tests;

   wiper_ctl u_wiper_ctl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cs_oe(cs_oe),
      .cs_level(cs_level), .ud_out(ud_out));
   wiper_dev_model u_wiper_dev_model (.pclk(pclk), .cs_oe(cs_oe), .cs_level(cs_level), .ud_out(ud_out),
      .dev_pos(dev_pos), .dev_nv(dev_nv), .dev_frz(dev_frz), .dev_faults(dev_faults));

   always #5 pclk = ~pclk;

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic final_report;
      if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // bench's own reckoning of the device, then the pin command
   task automatic issue(input logic elev, input logic up, input logic keep, input int steps);
      int   i;
      logic k;
      for (i = 0; i < steps && i < 64; i++)
         if (elev || !efrz) epos = up ? (epos == 6'h3F ? epos : epos + 6'h01) : (epos == 6'h00 ? epos : epos - 6'h01);
      k = keep & ((steps != 0) | up);
      if (elev) begin
         env  = epos;
         efrz = k;
      end else if (k && !efrz) begin
         env = epos;
      end
      apb(1'b1, ADDR_CTRL, {17'h0, 7'(steps), 4'h0, keep, up, elev, 1'b1}, rd, err);
   endtask : issue

   task automatic settle;
      int n;
      n = 0;
      do begin
         apb(1'b0, ADDR_STATUS, 32'h0000_0000, rd, err);
         n++;
      end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 1000);
      chk("status", {10'h0, env, 2'b0, epos, 5'b0, efrz, 2'b10}, rd);
      chk("dev_pos", {26'h0, epos}, {26'h0, dev_pos});
      chk("dev_nv", {26'h0, env}, {26'h0, dev_nv});
      chk("dev_frz", {31'h0, efrz}, {31'h0, dev_frz});
      chk("cs_oe", 32'h0000_0000, {31'h0, cs_oe});
   endtask : settle

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      apb(1'b0, ADDR_STATUS, 32'h0000_0000, rd, err);
      chk("status_rst", 32'h001F_1F00, rd);
      apb(1'b0, ADDR_SHADOW, 32'h0000_0000, rd, err);
      chk("shadow_rst", 32'h0000_001F, rd);
      apb(1'b0, ADDR_DIV, 32'h0000_0000, rd, err);
      chk("div_rst", 32'h0000_0031, rd);
      chk("mapped_ok", 32'h0000_0000, {31'h0, err});
      apb(1'b1, ADDR_SHADOW, 32'h0000_012A, rd, err);
      apb(1'b0, ADDR_SHADOW, 32'h0000_0000, rd, err);
      chk("shadow_rw", 32'h0000_012A, rd);
      apb(1'b0, ADDR_STATUS, 32'h0000_0000, rd, err);
      chk("status_shd", 32'h002A_2A04, rd);
      apb(1'b1, ADDR_SHADOW, 32'h0000_001F, rd, err);
      apb(1'b0, ADDR_SHADOW, 32'h0000_0000, rd, err);
      chk("shadow_back", 32'h0000_001F, rd);
      apb(1'b0, 12'h010, 32'h0000_0000, rd, err);
      chk("unmapped_err", 32'h0000_0001, {31'h0, err});
   endtask : t_reset

   task automatic t_normal;
      apb(1'b1, ADDR_DIV, 32'h0000_0001, rd, err);
      apb(1'b0, ADDR_DIV, 32'h0000_0000, rd, err);
      chk("div_rw", 32'h0000_0001, rd);
      issue(1'b0, 1'b1, 1'b1, 3);
      settle();
      issue(1'b0, 1'b0, 1'b0, 2);
      settle();
      issue(1'b0, 1'b1, 1'b1, 0);
      apb(1'b0, ADDR_CTRL, 32'h0000_0000, rd, err);
      chk("ctrl_rb", 32'h0000_000C, rd);
      settle();
      issue(1'b0, 1'b0, 1'b1, 0);
      settle();
   endtask : t_normal

   task automatic t_saturate;
      apb(1'b1, ADDR_DIV, 32'h0000_0000, rd, err);
      issue(1'b0, 1'b1, 1'b1, 64);
      settle();
      issue(1'b0, 1'b1, 1'b0, 2);
      settle();
      issue(1'b0, 1'b0, 1'b0, 64);
      settle();
   endtask : t_saturate

   task automatic t_freeze;
      issue(1'b1, 1'b1, 1'b1, 1);
      settle();
      issue(1'b0, 1'b1, 1'b1, 5);
      settle();
      issue(1'b1, 1'b0, 1'b1, 2);
      settle();
      issue(1'b1, 1'b1, 1'b0, 1);
      settle();
      issue(1'b0, 1'b1, 1'b1, 1);
      settle();
   endtask : t_freeze

   task automatic t_busy;
      issue(1'b0, 1'b1, 1'b0, 4);
      apb(1'b1, ADDR_CTRL, 32'h0000_0403, rd, err);
      settle();
      chk("pin_faults", 32'h0000_0000, 32'(dev_faults));
   endtask : t_busy

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      pclk      = 1'b0;
      presetn   = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 12'h000;
      pwdata    = 32'h0000_0000;
      bad_count = 0;
      n_tests   = 0;
      epos      = 6'h1F;
      env       = 6'h1F;
      efrz      = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_normal();
      t_saturate();
      t_freeze();
      t_busy();
      final_report();
   end

   initial begin
      #500_000;
      bad_count++;
      final_report();
   end
endmodule : wiper_ctl_tb
